// *** logic/vcc_pkg.sv ***
// package of register offsets, field positions and reset values
package vcc_pkg;
    localparam int VCC_NUM_CMP = 3;
    localparam int VCC_ADDR_W = 4;
    // register offsets: control and mode per comparator, then shared
    localparam logic [3:0] VCC_OFF_CTRL0 = 4'h0;
    localparam logic [3:0] VCC_OFF_MODE0 = 4'h1;
    localparam logic [3:0] VCC_OFF_CTRL1 = 4'h2;
    localparam logic [3:0] VCC_OFF_MODE1 = 4'h3;
    localparam logic [3:0] VCC_OFF_CTRL2 = 4'h4;
    localparam logic [3:0] VCC_OFF_MODE2 = 4'h5;
    localparam logic [3:0] VCC_OFF_EXT_IE = 4'h6;
    localparam logic [3:0] VCC_OFF_ISTAT = 4'h7;
    localparam logic [3:0] VCC_OFF_ICLR = 4'h8;
    localparam logic [3:0] VCC_OFF_IEN = 4'h9;
    // control register fields
    localparam int VCC_CTL_ON = 7;
    localparam int VCC_CTL_RESULT = 6;
    localparam int VCC_CTL_RISE = 5;
    localparam int VCC_CTL_FALL = 4;
    localparam int VCC_CTL_HYP = 2;
    localparam int VCC_CTL_HYN = 0;
    // mode register fields
    localparam int VCC_MD_RIE = 5;
    localparam int VCC_MD_FIE = 4;
    localparam int VCC_MD_RESP = 0;
    // reset values
    localparam logic [1:0] VCC_RESP_RST = 2'h2;
    localparam logic [1:0] VCC_HYST_RST = 2'h0;
    // synchroniser depth
    localparam int VCC_SYNC_STAGES = 2;
endpackage : vcc_pkg

// *** logic/vcc_edge_sync.sv ***
// one comparator output: synchroniser and edge detector
`timescale 1ns/1ps
module vcc_edge_sync
    import vcc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // asynchronous comparator level
    input wire logic raw_in,
    // synchronised level and edge pulses
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic [VCC_SYNC_STAGES-1:0] sync;
        logic last;
    } vcc_es_s;

    vcc_es_s st;
    vcc_es_s next_st;

    // shift in; only the final stage feeds the edge compare
    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[VCC_SYNC_STAGES-2:0], raw_in};
        next_st.last = st.sync[VCC_SYNC_STAGES-1];
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign level = st.sync[VCC_SYNC_STAGES-1];
    assign rise = st.sync[VCC_SYNC_STAGES-1] & ~st.last;
    assign fall = ~st.sync[VCC_SYNC_STAGES-1] & st.last;
endmodule : vcc_edge_sync

// *** logic/vcc_comparator_ctrl.sv ***
// control, flags and interrupt logic for three voltage comparators
// How it works
// - three comparators, each powered while its on bit is one.
// - a disabled comparator drives its pin output low.
// - result bit is readable anytime, reading has no side effects.
// - rising and falling edge interrupt enables sit in the mode register.
// - falling output edge sets a sticky fall flag until software clears.
// - rising output edge sets a sticky rise flag until software clears.
// - per comparator interrupt forwarded only when also enabled in the extended enable reg.
// - hysteresis comes from control bits three to zero, two fields.
// - each hysteresis field picks off, 5, 10 or 20 mV.
// - two-bit response field in mode register trades speed for power.
// - outputs also serve as port pin outputs; comparator 0 output also as reset source.
`timescale 1ns/1ps
module vcc_comparator_ctrl
    import vcc_pkg::*;
#(
    parameter int NUM_CMP = VCC_NUM_CMP
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [VCC_ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // analog front end
    input wire logic [NUM_CMP-1:0] cmp_raw,
    output logic [NUM_CMP-1:0] cmp_on,
    output logic [2*NUM_CMP-1:0] pos_hyst_sel,
    output logic [2*NUM_CMP-1:0] neg_hyst_sel,
    output logic [2*NUM_CMP-1:0] response_sel,
    // pin, reset and interrupt outputs
    output logic [NUM_CMP-1:0] cmp_pin_out,
    output logic cmp0_reset_src,
    output logic [NUM_CMP-1:0] cmp_irq,
    output logic irq
);
    typedef struct packed {
        logic [NUM_CMP-1:0] on;
        logic [NUM_CMP-1:0] rise_flag;
        logic [NUM_CMP-1:0] fall_flag;
        logic [NUM_CMP-1:0] rise_ie;
        logic [NUM_CMP-1:0] fall_ie;
        logic [2*NUM_CMP-1:0] hyp;
        logic [2*NUM_CMP-1:0] hyn;
        logic [2*NUM_CMP-1:0] resp;
        logic [NUM_CMP-1:0] ext_ie;
        logic [2*NUM_CMP-1:0] istat;
        logic [2*NUM_CMP-1:0] ien;
        logic [7:0] rdata;
    } vcc_s;

    vcc_s st;
    vcc_s next_st;
    logic [NUM_CMP-1:0] lvl;
    logic [NUM_CMP-1:0] rise_p;
    logic [NUM_CMP-1:0] fall_p;
    logic [NUM_CMP-1:0] res;
    logic [NUM_CMP-1:0] rise_ev;
    logic [NUM_CMP-1:0] fall_ev;

    // one synchroniser per comparator
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++)
        begin : g_cmp
            vcc_edge_sync u_sync (
                .mclk(mclk),
                .rst_n(rst_n),
                .raw_in(cmp_raw[gi]),
                .level(lvl[gi]),
                .rise(rise_p[gi]),
                .fall(fall_p[gi])
            );
        end
    endgenerate

    // a shut-down comparator has no meaningful output, so mask it low
    assign res = lvl & st.on;
    // edges only count while powered, avoids flags from enable glitches
    assign rise_ev = rise_p & st.on;
    assign fall_ev = fall_p & st.on;

    // register writes, flag updates and read mux
    always_comb
    begin
        next_st = st;
        next_st.rdata = 8'h00;
        for (int i = 0; i < NUM_CMP; i++)
        begin
            // software write of control clears or sets flags; event wins
            if (wr && addr == VCC_OFF_CTRL0 + 4'(2*i))
            begin
                next_st.on[i] = wdata[VCC_CTL_ON];
                next_st.rise_flag[i] = wdata[VCC_CTL_RISE];
                next_st.fall_flag[i] = wdata[VCC_CTL_FALL];
                next_st.hyp[2*i +: 2] = wdata[VCC_CTL_HYP +: 2];
                next_st.hyn[2*i +: 2] = wdata[VCC_CTL_HYN +: 2];
            end
            if (wr && addr == VCC_OFF_MODE0 + 4'(2*i))
            begin
                next_st.rise_ie[i] = wdata[VCC_MD_RIE];
                next_st.fall_ie[i] = wdata[VCC_MD_FIE];
                next_st.resp[2*i +: 2] = wdata[VCC_MD_RESP +: 2];
            end
            if (rise_ev[i])
                next_st.rise_flag[i] = 1'b1;
            if (fall_ev[i])
                next_st.fall_flag[i] = 1'b1;
            // reads carry no side effects on any flag
            if (rd && addr == VCC_OFF_CTRL0 + 4'(2*i))
            begin
                next_st.rdata[VCC_CTL_ON] = st.on[i];
                next_st.rdata[VCC_CTL_RESULT] = res[i];
                next_st.rdata[VCC_CTL_RISE] = st.rise_flag[i];
                next_st.rdata[VCC_CTL_FALL] = st.fall_flag[i];
                next_st.rdata[VCC_CTL_HYP +: 2] = st.hyp[2*i +: 2];
                next_st.rdata[VCC_CTL_HYN +: 2] = st.hyn[2*i +: 2];
            end
            if (rd && addr == VCC_OFF_MODE0 + 4'(2*i))
            begin
                next_st.rdata[VCC_MD_RIE] = st.rise_ie[i];
                next_st.rdata[VCC_MD_FIE] = st.fall_ie[i];
                next_st.rdata[VCC_MD_RESP +: 2] = st.resp[2*i +: 2];
            end
        end
        // shared registers
        if (wr && addr == VCC_OFF_EXT_IE)
            next_st.ext_ie = wdata[NUM_CMP-1:0];
        if (wr && addr == VCC_OFF_IEN)
            next_st.ien = wdata[2*NUM_CMP-1:0];
        if (wr && addr == VCC_OFF_ICLR)
            next_st.istat = st.istat & ~wdata[2*NUM_CMP-1:0];
        // sticky status: set beats the clear in the same cycle
        next_st.istat = next_st.istat | {fall_ev, rise_ev};
        if (rd && addr == VCC_OFF_EXT_IE)
            next_st.rdata[NUM_CMP-1:0] = st.ext_ie;
        if (rd && addr == VCC_OFF_ISTAT)
            next_st.rdata[2*NUM_CMP-1:0] = st.istat;
        if (rd && addr == VCC_OFF_IEN)
            next_st.rdata[2*NUM_CMP-1:0] = st.ien;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.resp <= {NUM_CMP{VCC_RESP_RST}};
            st.hyp <= {NUM_CMP{VCC_HYST_RST}};
            st.hyn <= {NUM_CMP{VCC_HYST_RST}};
        end
        else
            st <= next_st;
    end

    // outputs to the analog side and the system
    assign rdata = st.rdata;
    assign cmp_on = st.on;
    assign pos_hyst_sel = st.hyp;
    assign neg_hyst_sel = st.hyn;
    assign response_sel = st.resp;
    assign cmp_pin_out = res;
    // caller must respect power-up time before arming this reset source
    assign cmp0_reset_src = res[0];
    // per comparator interrupt: flag and edge enable and system enable
    assign cmp_irq = ((st.rise_flag & st.rise_ie)
                     | (st.fall_flag & st.fall_ie)) & st.ext_ie;
    assign irq = |(st.istat & st.ien);

    // checks: power, pin output and result read
    a_pin_low_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !st.on[0] |-> !cmp_pin_out[0])
        else $error("pin output high while comparator off");
    a_on_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_CTRL0
        |=> cmp_on[0] == $past(wdata[VCC_CTL_ON]))
        else $error("enable write not taken");
    a_result_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rd && addr == VCC_OFF_CTRL0
        |=> rdata[VCC_CTL_RESULT] == $past(res[0]))
        else $error("result bit read wrong");
    a_result_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rd && addr == VCC_OFF_CTRL2 && !st.on[2]
        |=> !rdata[VCC_CTL_RESULT])
        else $error("switched off comparator read as high");
    a_pin_result: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rd && addr == VCC_OFF_CTRL0
        |=> rdata[VCC_CTL_RESULT] == $past(cmp_pin_out[0]))
        else $error("pin output and result bit disagree");
    a_rdata_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00)
        else $error("read data not zero without a read");

    // edge flags; a set must survive everything but a software write
    a_rise_sets: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise_ev[0] |=> st.rise_flag[0])
        else $error("rise flag not set after rising edge");
    a_fall_sets: assert property (
        @(posedge mclk) disable iff (!rst_n)
        fall_ev[0] |=> st.fall_flag[0])
        else $error("fall flag not set after falling edge");
    a_flag_sticky: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.rise_flag[0] && !wr |=> st.rise_flag[0])
        else $error("rise flag dropped without write");
    a_read_no_clr: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rd && st.fall_flag[0] |=> st.fall_flag[0])
        else $error("read cleared a flag");
    a_ctrl_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_CTRL0 && !wdata[VCC_CTL_RISE] && !rise_ev[0]
        |=> !st.rise_flag[0])
        else $error("software clear of rise flag not taken");
    a_off_no_flag: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !st.on[2] && !wr
        |=> st.fall_flag[2] == $past(st.fall_flag[2]))
        else $error("flag moved while comparator off");
    a_sync_delay: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(cmp_raw[0]) ##2 st.on[0]
        |=> st.rise_flag[0])
        else $error("synchroniser latency wrong");

    // status register and the shared interrupt line
    a_istat_set: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rise_ev[0] |=> st.istat[0])
        else $error("status bit not set after rising edge");
    a_istat_stick: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.istat[3] && !(wr && addr == VCC_OFF_ICLR)
        |=> st.istat[3])
        else $error("status bit dropped without clear");
    a_irq_level: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.istat[3] && st.ien[3] |-> irq)
        else $error("enabled status bit gave no interrupt");

    // per comparator interrupt gating
    a_irq_gated: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !st.ext_ie[0] |-> !cmp_irq[0])
        else $error("interrupt without system enable");
    a_irq_edge_en: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.ext_ie[0] && st.rise_ie[0] && st.rise_flag[0]
        |-> cmp_irq[0])
        else $error("enabled rise flag gave no interrupt");
    a_fall_irq_en: assert property (
        @(posedge mclk) disable iff (!rst_n)
        st.ext_ie[0] && st.fall_ie[0] && st.fall_flag[0]
        |-> cmp_irq[0])
        else $error("enabled fall flag gave no interrupt");
    a_no_edge_en: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !st.rise_ie[0] && !st.fall_ie[0]
        |-> !cmp_irq[0])
        else $error("interrupt without any edge enable");
    a_ie_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_MODE0
        |=> st.fall_ie[0] == $past(wdata[VCC_MD_FIE]))
        else $error("edge enable write not taken");

    // analog settings follow their register fields
    a_hyst_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_CTRL1
        |=> pos_hyst_sel[3:2] == $past(wdata[VCC_CTL_HYP +: 2]))
        else $error("hysteresis write not taken");
    a_hyn_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_CTRL1
        |=> neg_hyst_sel[3:2] == $past(wdata[VCC_CTL_HYN +: 2]))
        else $error("negative hysteresis write not taken");
    a_resp_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr && addr == VCC_OFF_MODE2
        |=> response_sel[5:4] == $past(wdata[VCC_MD_RESP +: 2]))
        else $error("response write not taken");
    a_mode_read: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rd && addr == VCC_OFF_MODE2
        |=> rdata[VCC_MD_RESP +: 2] == $past(response_sel[5:4]))
        else $error("response field read wrong");

    // main scenarios
    c_edge_irq: cover property (@(posedge mclk) disable iff (!rst_n)
        (rise_ev[0] || fall_ev[0]) ##1 cmp_irq[0]);
    c_fall_flag: cover property (@(posedge mclk) disable iff (!rst_n)
        fall_ev[0] ##1 st.fall_flag[0]);
    c_clear_flag: cover property (@(posedge mclk) disable iff (!rst_n)
        st.rise_flag[0] ##1 !st.rise_flag[0]);
    c_top_irq: cover property (@(posedge mclk) disable iff (!rst_n) irq);
    c_result_hi: cover property (@(posedge mclk) disable iff (!rst_n)
        rd && addr == VCC_OFF_CTRL0 ##1 rdata[VCC_CTL_RESULT]);
endmodule : vcc_comparator_ctrl

// *** tb/vcc_far_side.sv ***
// analog comparator outputs and interrupt handler facing the block
`timescale 1ns/1ps
module vcc_far_side
    import vcc_pkg::*;
(
    // levels asked for by the bench
    input wire logic [VCC_NUM_CMP-1:0] level_req,
    // interrupt from the block
    input wire logic irq,
    // analog outputs and handler count
    output logic [VCC_NUM_CMP-1:0] cmp_raw,
    output int irq_seen
);
    // outputs move off the clock grid so the synchroniser is exercised
    initial
    begin
        cmp_raw = '0;
        forever
        begin
            @(level_req);
            cmp_raw <= #1.3 level_req;
        end
    end
    // handler counts every request it is offered
    initial
    begin
        irq_seen = 0;
        forever
        begin
            @(posedge irq);
            irq_seen = irq_seen + 1;
        end
    end
endmodule : vcc_far_side

// *** tb/voltage_comparator_control_tb_top.sv ***
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module voltage_comparator_control_tb_top
    import vcc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] level_req = 3'h0;
    logic [2:0] cmp_raw, cmp_on, cmp_pin_out, cmp_irq;
    logic [5:0] pos_hyst_sel, neg_hyst_sel, response_sel;
    logic cmp0_reset_src, irq;
    logic [7:0] rv;
    int irq_seen;
    int errors = 0;
    int checks = 0;

    // 250 MHz system clock
    always #2 mclk = ~mclk;

    vcc_comparator_ctrl i_dut (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .cmp_raw(cmp_raw), .cmp_on(cmp_on),
        .pos_hyst_sel(pos_hyst_sel), .neg_hyst_sel(neg_hyst_sel),
        .response_sel(response_sel), .cmp_pin_out(cmp_pin_out),
        .cmp0_reset_src(cmp0_reset_src), .cmp_irq(cmp_irq), .irq(irq)
    );
    vcc_far_side i_far (
        .level_req(level_req), .irq(irq), .cmp_raw(cmp_raw),
        .irq_seen(irq_seen)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle strobes; each call lets an edge pass before the next
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk

    task automatic set_level(input logic [2:0] lv, input int n);
        @(posedge mclk);
        level_req <= lv;
        repeat (n) @(posedge mclk);
        #1;
    endtask : set_level

    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 10)
        begin
            @(posedge mclk);
            n++;
        end
        #1;
        chk({7'h0, irq}, 8'h01);
        // a line that never rose ends the run as a failure
        if (irq !== 1'b1)
            test_done();
    endtask : wait_irq

    // a hang counts as a mismatch
    initial
    begin
        #100000;
        errors++;
        test_done();
    end

    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(VCC_OFF_CTRL0 + 4'(2 * i), 8'h00);
            rd_chk(VCC_OFF_MODE0 + 4'(2 * i), 8'h02);
        end
        rd_chk(4'hF, 8'h00);
        chk({2'h0, response_sel}, 8'h2A);
        $display("test reset values done");
        // every hysteresis and response code, set back to back
        for (int h = 0; h < 4; h++)
        begin
            wr_reg(VCC_OFF_CTRL1, 8'h80 | 8'(h << 2) | 8'(3 - h));
            wr_reg(VCC_OFF_MODE2, 8'hC0 | 8'(h));
            chk({6'h0, pos_hyst_sel[3:2]}, 8'(h));
            chk({6'h0, neg_hyst_sel[3:2]}, 8'(3 - h));
            chk({6'h0, response_sel[5:4]}, 8'(h));
            chk({5'h0, cmp_on}, 8'h02);
        end
        rd_chk(VCC_OFF_MODE2, 8'h03);
        rd_chk(VCC_OFF_CTRL1, 8'h8C);
        $display("test hysteresis and response done");
        // a switched-off comparator ignores its input
        set_level(3'b100, 6);
        chk({7'h0, cmp_pin_out[2]}, 8'h00);
        rd_chk(VCC_OFF_CTRL2, 8'h00);
        wr_reg(VCC_OFF_CTRL0, 8'h80);
        repeat (8) @(posedge mclk);
        // rising edge: two sync stages before anything moves
        set_level(3'b101, 1);
        chk({7'h0, cmp_pin_out[0]}, 8'h00);
        repeat (3) @(posedge mclk);
        rd_chk(VCC_OFF_CTRL0, 8'hE0);
        rd_chk(VCC_OFF_CTRL0, 8'hE0);
        chk({6'h0, cmp0_reset_src, cmp_pin_out[0]}, 8'h03);
        set_level(3'b100, 5);
        rd_chk(VCC_OFF_CTRL0, 8'hB0);
        rd_chk(VCC_OFF_ISTAT, 8'h09);
        wr_reg(VCC_OFF_CTRL0, 8'h80);
        wr_reg(VCC_OFF_ICLR, 8'h09);
        rd_chk(VCC_OFF_CTRL0, 8'h80);
        rd_chk(VCC_OFF_ISTAT, 8'h00);
        $display("test edge flags done");
        // edge enables gated by the extended enable
        wr_reg(VCC_OFF_MODE0, 8'h20);
        set_level(3'b101, 5);
        chk({5'h0, cmp_irq}, 8'h00);
        wr_reg(VCC_OFF_EXT_IE, 8'h01);
        chk({5'h0, cmp_irq}, 8'h01);
        rd_chk(VCC_OFF_EXT_IE, 8'h01);
        wr_reg(VCC_OFF_MODE0, 8'h10);
        chk({5'h0, cmp_irq}, 8'h00);
        set_level(3'b100, 5);
        chk({5'h0, cmp_irq}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr_reg(VCC_OFF_IEN, 8'h08);
        rd_chk(VCC_OFF_IEN, 8'h08);
        wait_irq();
        chk(8'(irq_seen), 8'h01);
        wr_reg(VCC_OFF_ICLR, 8'h08);
        chk({7'h0, irq}, 8'h00);
        $display("test interrupts done");
        test_done();
    end
endmodule : voltage_comparator_control_tb_top
